// File: src/taicd_top.sv
// Touch converter I2C slave: address match, command byte decode and APB status access.
`timescale 1ns/10ps
module taicd_top #(
    parameter logic [4:0] DEV_TYPE = 5'h0b
)(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [taicd_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // I2C pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_strap_hi,
    input wire logic addr_strap_lo,
    // Converter side
    input wire logic conv_done,
    input wire logic pen_lifted,
    input wire logic abort_done,
    output taicd_pkg::taicd_conv_t conv,
    output taicd_pkg::taicd_regacc_t regacc,
    output logic [15:0] config_reg_zero
);
    import taicd_pkg::*;

    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic [1:0] hi_sync;
        logic [1:0] lo_sync;
        logic scl_q;
        logic sda_q;
        logic [1:0] strap_cnt;
        logic strap_taken;
        logic [1:0] strap;
        taicd_phase_t phase;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic byte_full;
        logic in_ack;
        logic ack_drive;
        logic addr_ok;
        logic [6:0] match_addr;
        logic last_dir;
        logic data_hi_done;
        logic [7:0] data_hi;
        logic [3:0] wptr;
        logic ctrl_en;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic sda_oe;
        taicd_conv_t cv;
        taicd_regacc_t ra;
        logic [15:0] cfg0;
    } taicd_state_t;

    taicd_state_t st;
    taicd_state_t next_st;

    // ==========================================================
    // Function code decoding
    function automatic logic fn_single(input logic [3:0] f);
        fn_single = (f >= FN_X) && (f <= FN_IY);
    endfunction

    function automatic logic fn_pen_scan(input logic [3:0] f);
        fn_pen_scan = (f == FN_SCAN_XYZ) || (f == FN_SCAN_XY);
    endfunction

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] rx;
    logic apb_done;

    // ==========================================================
    // Next state
    always_comb
    begin
        next_st = st;
        rx = st.shreg;
        next_st.scl_sync = {st.scl_sync[0], scl_in};
        next_st.sda_sync = {st.sda_sync[0], sda_in};
        next_st.hi_sync = {st.hi_sync[0], addr_strap_hi};
        next_st.lo_sync = {st.lo_sync[0], addr_strap_lo};
        next_st.scl_q = st.scl_sync[1];
        next_st.sda_q = st.sda_sync[1];
        scl_rise = st.scl_sync[1] && !st.scl_q;
        scl_fall = !st.scl_sync[1] && st.scl_q;
        start_seen = st.scl_sync[1] && st.scl_q && st.sda_q && !st.sda_sync[1];
        stop_seen = st.scl_sync[1] && st.scl_q && !st.sda_q && st.sda_sync[1];
        next_st.cv.conv_start = 1'b0;
        next_st.cv.soft_reset = 1'b0;
        next_st.ra.ptr_load = 1'b0;
        next_st.ra.wr_strobe = 1'b0;
        next_st.ra.read_req = 1'b0;

        // Straps are caught once, after they have crossed the synchroniser.
        if (!st.strap_taken)
        begin
            if (st.strap_cnt == STRAP_WAIT)
            begin
                next_st.strap = {st.hi_sync[1], st.lo_sync[1]};
                next_st.strap_taken = 1'b1;
            end
            else
            begin
                next_st.strap_cnt = st.strap_cnt + 2'h1;
            end
        end

        // Converter completion events.
        if (st.cv.conv_busy && fn_single(st.cv.conv_func) && conv_done)
        begin
            next_st.cv.conv_busy = 1'b0;
        end
        if (st.cv.conv_busy && fn_pen_scan(st.cv.conv_func) && pen_lifted)
        begin
            next_st.cv.conv_busy = 1'b0;
        end
        if (abort_done)
        begin
            next_st.cv.abort_req = 1'b0;
        end

        // Serial byte engine.
        if (start_seen)
        begin
            next_st.phase = st.ctrl_en ? TAICD_ADDR : TAICD_IGNORE;
            next_st.bit_cnt = 4'h0;
            next_st.byte_full = 1'b0;
            next_st.in_ack = 1'b0;
            next_st.sda_oe = 1'b0;
            next_st.data_hi_done = 1'b0;
        end
        else if (stop_seen)
        begin
            // An odd data byte left unpaired at stop is dropped.
            next_st.phase = TAICD_IDLE;
            next_st.sda_oe = 1'b0;
            next_st.in_ack = 1'b0;
            next_st.data_hi_done = 1'b0;
        end
        else if (st.phase != TAICD_IDLE && st.phase != TAICD_IGNORE)
        begin
            if (scl_rise && !st.in_ack && !st.byte_full)
            begin
                next_st.shreg = {st.shreg[6:0], st.sda_sync[1]};
                next_st.bit_cnt = st.bit_cnt + 4'h1;
                next_st.byte_full = (st.bit_cnt == 4'(BIT_LAST));
            end
            else if (scl_fall && st.byte_full)
            begin
                // Byte complete: act on it and open the acknowledge slot, except after an address byte that does not match.
                next_st.byte_full = 1'b0;
                next_st.bit_cnt = 4'h0;
                next_st.in_ack = 1'b1;
                next_st.sda_oe = 1'b1;
                unique case (st.phase)
                    TAICD_ADDR:
                    begin
                        next_st.match_addr = rx[7:1];
                        next_st.last_dir = rx[0];
                        if (st.strap_taken && rx[7:3] == DEV_TYPE && rx[2:1] == st.strap)
                        begin
                            next_st.addr_ok = 1'b1;
                            next_st.ra.read_req = (rx[0] == DIR_READ);
                        end
                        else
                        begin
                            next_st.addr_ok = 1'b0;
                            next_st.sda_oe = 1'b0;
                            next_st.in_ack = 1'b0;
                            next_st.phase = TAICD_IGNORE;
                        end
                    end
                    TAICD_CMD:
                    begin
                        if (rx[CMD_FMT_BIT] == CMD_FMT_CONV)
                        begin
                            next_st.cv.resolution_select = rx[CMD_RES_BIT];
                            next_st.cfg0[CFG0_RES_BIT] = rx[CMD_RES_BIT];
                            if (rx[CMD_SOFT_RESET_BIT_BIT])
                            begin
                                // Reset wins over everything else in the same byte.
                                next_st.cv = '0;
                                next_st.cv.soft_reset = 1'b1;
                                next_st.cfg0 = CFG0_RST;
                                next_st.ra.read_ptr = PTR_RST;
                            end
                            else if (rx[CMD_STOP_BIT])
                            begin
                                // Stop leaves data copies untouched; the configuration copy still takes the byte's resolution bit.
                                next_st.cv.abort_req = 1'b1;
                                next_st.cv.conv_busy = 1'b0;
                                next_st.cv.drv_x_pair = 1'b0;
                                next_st.cv.drv_y_pair = 1'b0;
                                next_st.cv.drv_yx_pair = 1'b0;
                                next_st.cv.reserved_hold = 1'b0;
                            end
                            else
                            begin
                                next_st.cv.conv_func = rx[CMD_FIELD_HI:CMD_FIELD_LO];
                                next_st.cv.drv_x_pair = (rx[CMD_FIELD_HI:CMD_FIELD_LO] == FN_DRV_X);
                                next_st.cv.drv_y_pair = (rx[CMD_FIELD_HI:CMD_FIELD_LO] == FN_DRV_Y);
                                next_st.cv.drv_yx_pair = (rx[CMD_FIELD_HI:CMD_FIELD_LO] == FN_DRV_YX);
                                if (rx[CMD_FIELD_HI:CMD_FIELD_LO] == FN_RSV_HOLD)
                                begin
                                    next_st.cv.reserved_hold = 1'b1;
                                end
                                if (rx[CMD_FIELD_HI:CMD_FIELD_LO] <= FN_AUX_CONT)
                                begin
                                    next_st.cv.conv_start = 1'b1;
                                    next_st.cv.conv_busy = 1'b1;
                                end
                            end
                        end
                        else
                        begin
                            next_st.cv.bias_keep_on = rx[CMD_BIAS_BIT];
                            if (rx[CMD_PTR_BIT] == DIR_READ)
                            begin
                                next_st.ra.read_ptr = rx[CMD_FIELD_HI:CMD_FIELD_LO];
                                next_st.ra.ptr_load = 1'b1;
                            end
                            else
                            begin
                                next_st.wptr = rx[CMD_FIELD_HI:CMD_FIELD_LO];
                            end
                        end
                    end
                    TAICD_DATA:
                    begin
                        if (!st.data_hi_done)
                        begin
                            next_st.data_hi = rx;
                            next_st.data_hi_done = 1'b1;
                        end
                        else
                        begin
                            next_st.data_hi_done = 1'b0;
                            next_st.ra.wr_data = {st.data_hi, rx};
                            next_st.ra.wr_addr = st.wptr;
                            next_st.ra.wr_strobe = 1'b1;
                            next_st.wptr = st.wptr + 4'h1;
                            if (st.wptr == REG_CFG0)
                            begin
                                next_st.cfg0 = {st.data_hi, rx};
                                next_st.cv.resolution_select = st.data_hi[CFG0_RES_BIT-8];
                            end
                        end
                    end
                    default:
                    begin
                        next_st.phase = TAICD_IGNORE;
                    end
                endcase
            end
            else if (scl_fall && st.in_ack)
            begin
                // The acknowledge slot ends; decide where the next byte goes.
                next_st.in_ack = 1'b0;
                next_st.sda_oe = 1'b0;
                unique case (st.phase)
                    TAICD_ADDR:
                    begin
                        // Read sequencing lives elsewhere; this block stays off SDA for it.
                        next_st.phase = (st.last_dir == DIR_READ) ? TAICD_IGNORE : TAICD_CMD;
                    end
                    TAICD_CMD:
                    begin
                        next_st.phase = (st.shreg[CMD_FMT_BIT] != CMD_FMT_CONV && st.shreg[CMD_PTR_BIT] != DIR_READ)
                            ? TAICD_DATA : TAICD_IGNORE;
                    end
                    default:
                    begin
                        next_st.phase = st.phase;
                    end
                endcase
            end
        end

        // The stop state mirrors into the configuration copy; set beats a completing abort.
        next_st.cfg0[CFG0_STOP_BIT] = next_st.cv.abort_req;

        // APB slave: one wait state, answer registered.
        apb_done = psel && penable && st.pready;
        next_st.pready = psel && penable && !st.pready;
        next_st.pslverr = 1'b0;
        next_st.prdata = 32'h0000_0000;
        if (psel && penable && !st.pready)
        begin
            unique case (paddr)
                OFS_CTRL:
                begin
                    next_st.prdata = {31'h0000_0000, st.ctrl_en};
                end
                OFS_STATUS:
                begin
                    next_st.prdata = {7'h00, st.cv.reserved_hold, st.cv.drv_yx_pair, st.cv.drv_y_pair,
                        st.cv.drv_x_pair, st.strap_taken, st.ra.read_ptr, st.cv.resolution_select,
                        st.cv.bias_keep_on, st.cv.abort_req, st.cv.conv_busy, st.cv.conv_func,
                        st.last_dir, st.match_addr};
                end
                OFS_CFG0:
                begin
                    next_st.prdata = {16'h0000, st.cfg0};
                end
                OFS_LASTWR:
                begin
                    next_st.prdata = {12'h000, st.ra.wr_addr, st.ra.wr_data};
                end
                default:
                begin
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_done && pwrite && paddr == OFS_CTRL)
        begin
            next_st.ctrl_en = pwdata[CTRL_EN_BIT];
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.scl_sync <= 2'h3;
            st.sda_sync <= 2'h3;
            st.scl_q <= 1'b1;
            st.sda_q <= 1'b1;
            st.phase <= TAICD_IDLE;
            st.ctrl_en <= CTRL_EN_RST;
            st.cfg0 <= CFG0_RST;
            st.ra.read_ptr <= PTR_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs, each taken from a flip-flop except sda_out, which is tied low
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign sda_out = 1'b0;
    assign sda_oe = st.sda_oe;
    assign conv = st.cv;
    assign regacc = st.ra;
    assign config_reg_zero = st.cfg0;

endmodule

// File: src/taicd_pkg.sv
// Constants and carrier types for the touch converter I2C slave address and command decoder.
package taicd_pkg;

    // ==========================================================
    // Bus and register map
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] OFS_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] OFS_STATUS = 12'h004;
    localparam logic [APB_AW-1:0] OFS_CFG0 = 12'h008;
    localparam logic [APB_AW-1:0] OFS_LASTWR = 12'h00c;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;

    // ==========================================================
    // Address byte and command byte fields
    localparam logic DIR_READ = 1'b1;
    localparam int CMD_FMT_BIT = 7;
    localparam logic CMD_FMT_CONV = 1'b1;
    localparam int CMD_FIELD_HI = 6;
    localparam int CMD_FIELD_LO = 3;
    localparam int CMD_RES_BIT = 2;
    localparam int CMD_SOFT_RESET_BIT_BIT = 1;
    localparam int CMD_STOP_BIT = 0;
    localparam int CMD_BIAS_BIT = 1;
    localparam int CMD_PTR_BIT = 0;
    localparam int BIT_LAST = 7;

    // ==========================================================
    // Converter function codes
    localparam logic [3:0] FN_SCAN_XYZ = 4'h0;
    localparam logic [3:0] FN_SCAN_XY = 4'h1;
    localparam logic [3:0] FN_X = 4'h2;
    localparam logic [3:0] FN_Y = 4'h3;
    localparam logic [3:0] FN_Z = 4'h4;
    localparam logic [3:0] FN_AUX = 4'h5;
    localparam logic [3:0] FN_IX = 4'h6;
    localparam logic [3:0] FN_IY = 4'h7;
    localparam logic [3:0] FN_AUX_CONT = 4'h8;
    localparam logic [3:0] FN_RSV_HOLD = 4'hb;
    localparam logic [3:0] FN_DRV_X = 4'hd;
    localparam logic [3:0] FN_DRV_Y = 4'he;
    localparam logic [3:0] FN_DRV_YX = 4'hf;

    // ==========================================================
    // Internal register copies and reset values
    localparam logic [3:0] REG_CFG0 = 4'hc;
    localparam int CFG0_RES_BIT = 13;
    localparam int CFG0_STOP_BIT = 14;
    localparam logic [15:0] CFG0_RST = 16'h0000;
    localparam logic [3:0] PTR_RST = 4'h0;
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    typedef enum logic [2:0] {
        TAICD_IDLE, TAICD_ADDR, TAICD_CMD, TAICD_DATA, TAICD_IGNORE
    } taicd_phase_t;

    typedef struct packed {
        logic conv_start;
        logic [3:0] conv_func;
        logic conv_busy;
        logic resolution_select;
        logic abort_req;
        logic soft_reset;
        logic bias_keep_on;
        logic drv_x_pair;
        logic drv_y_pair;
        logic drv_yx_pair;
        logic reserved_hold;
    } taicd_conv_t;

    typedef struct packed {
        logic ptr_load;
        logic [3:0] read_ptr;
        logic wr_strobe;
        logic [3:0] wr_addr;
        logic [15:0] wr_data;
        logic read_req;
    } taicd_regacc_t;

endpackage

// File: verification/taicd_host_model.sv
// Behavioural I2C bus master that drives SCL and SDA toward the decoder.
`timescale 1ns/10ps
module taicd_host_model (
    // Bus lines
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    // ==========================================================
    // Bus cycles
    // SCL stands high between frames and only toggles inside one; SDA has a pull-up.
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // The long low phase leaves room for the slave's pin synchroniser delay.
    task automatic put(input logic v, output logic s);
        #250 sda_drv = v;
        #250 scl = 1'b1;
        #150 s = sda;
        #150 scl = 1'b0;
    endtask
    task automatic start();
        #250 sda_drv = 1'b1;
        #250 scl = 1'b1;
        #250 sda_drv = 1'b0;
        #250 scl = 1'b0;
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
            put(b[i], ack);
        put(1'b1, ack);
        ack = ~ack;
    endtask
    task automatic stop();
        #250 sda_drv = 1'b0;
        #250 scl = 1'b1;
        #250 sda_drv = 1'b1;
        #250;
    endtask
endmodule

// File: verification/taicd_top_props.sv
// Concurrent checks on the ports of the touch converter command decoder.
`timescale 1ns/10ps
module taicd_top_props (
    // Clock, reset and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Link and converter
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic abort_done,
    input wire taicd_pkg::taicd_conv_t conv,
    input wire logic [15:0] config_reg_zero
);
    import taicd_pkg::*;
    // ==========================================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence ack_begins;
        $rose(sda_oe);
    endsequence
    sequence ack_ends;
        ##[5:12] !sda_oe;
    endsequence
    a_ack_stands: assert property (ack_begins |-> sda_oe [*5])
        else $error("acknowledge too short");
    a_ack_releases: assert property (ack_begins |-> ack_ends)
        else $error("acknowledge held too long");
    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("sda driven high");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready outside access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero");
    a_start_pulse: assert property (conv.conv_start |=> !conv.conv_start)
        else $error("conversion start too long");
    a_reset_clears: assert property (conv.soft_reset |=> !conv.soft_reset && config_reg_zero == 16'h0000)
        else $error("soft reset did not clear");
    a_stop_mirror: assert property (config_reg_zero[CFG0_STOP_BIT] == conv.abort_req)
        else $error("stop state not in config copy");
    a_abort_clears: assert property (conv.abort_req && abort_done |=> !conv.abort_req)
        else $error("abort did not clear");
endmodule
bind taicd_top taicd_top_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sda_out(sda_out), .sda_oe(sda_oe),
    .abort_done(abort_done), .conv(conv), .config_reg_zero(config_reg_zero));

// File: verification/tb_taicd_top.sv
// Self-checking testbench for the touch converter command decoder.
`timescale 1ns/10ps
module tb_taicd_top;
    import taicd_pkg::*;
    // ==========================================================
    // Signals and instances
    localparam logic [4:0] DEV = 5'h0b; // Arbitrary device-type value.
    localparam logic [7:0] AW = {DEV, 2'b10, 1'b0};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, scl, sda_drv, sda_out, sda_oe, err, ack;
    logic strap_hi, strap_lo, conv_done, pen_lifted, abort_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] config_reg_zero;
    taicd_conv_t conv;
    taicd_regacc_t regacc;
    int errors = 0;
    int tests_run = 0;
    int starts = 0;
    int strobes = 0;
    wire logic sda = sda_drv & ~(sda_oe & ~sda_out);
    taicd_top #(.DEV_TYPE(DEV)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_hi(strap_hi),
        .addr_strap_lo(strap_lo), .conv_done(conv_done), .pen_lifted(pen_lifted), .abort_done(abort_done),
        .conv(conv), .regacc(regacc), .config_reg_zero(config_reg_zero));
    taicd_host_model host (.scl(scl), .sda_drv(sda_drv), .sda(sda));
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // The conv_start and wr_strobe pulses are counted so that a missing or doubled pulse shows up.
    always @(posedge pclk)
    begin
        if (conv.conv_start === 1'b1)
            starts++;
        if (regacc.wr_strobe === 1'b1)
            strobes++;
    end
    // ==========================================================
    // Shared tasks
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input logic [2:0] m);
        @(posedge pclk);
        {conv_done, pen_lifted, abort_done} <= m;
        @(posedge pclk);
        {conv_done, pen_lifted, abort_done} <= 3'b000;
        repeat (2) @(posedge pclk);
    endtask
    // Sends the address byte, then, if it is acknowledged, n bytes of d from its top byte down.
    task automatic xfer(input logic [7:0] a, input logic [23:0] d, input int n);
        logic k;
        host.start();
        host.send(a, ack);
        for (int i = 0; i < n && ack; i++)
            host.send(d[23-8*i -: 8], k);
        host.stop();
        repeat (4) @(posedge pclk);
    endtask
    task automatic cmd(input logic [7:0] c);
        xfer(AW, {c, 16'h0}, 1);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_regs();
        apb(1'b0, OFS_CTRL, 32'h0);
        cmp("ctrl", 32'h1, rd);
        apb(1'b0, OFS_STATUS, 32'h0);
        cmp("straps taken", 32'h1, rd[20]);
        apb(1'b1, 12'h010, 32'h1);
        cmp("unmapped", 32'h1, err);
        apb(1'b1, OFS_CFG0, 32'hffff);
        apb(1'b0, OFS_CFG0, 32'h0);
        cmp("cfg0", 32'h0, rd);
        $display("test regs done");
    endtask
    task automatic t_addr();
        xfer(AW, 24'h0, 0);
        cmp("ack own", 32'h1, ack);
        apb(1'b0, OFS_STATUS, 32'h0);
        cmp("address", {1'b0, AW[7:1]}, rd[7:0]);
        xfer(AW ^ 8'h80, 24'h0, 0);
        cmp("ack type", 32'h0, ack);
        xfer(AW ^ 8'h04, 24'h0, 0);
        cmp("ack strap", 32'h0, ack);
        @(posedge pclk);
        {strap_hi, strap_lo} <= 2'b01;
        xfer(AW | 8'h01, 24'h0, 0);
        cmp("ack read", 32'h1, ack);
        apb(1'b0, OFS_STATUS, 32'h0);
        cmp("read address", {1'b1, AW[7:1]}, rd[7:0]);
        $display("test addr done");
    endtask
    task automatic t_conv();
        for (int f = 0; f < 8; f++)
        begin
            cmd({1'b1, 4'(f), f[0], 2'b00});
            cmp("function", f, conv.conv_func);
            cmp("resolution", f[0] ? 3 : 0, {conv.resolution_select, config_reg_zero[CFG0_RES_BIT]});
            cmp("busy", 32'h1, conv.conv_busy);
            pulse(f < 2 ? 3'b010 : 3'b100);
            cmp("idle", 32'h0, conv.conv_busy);
        end
        cmd(8'hc0);
        cmp("aux cont", 32'h11, {conv.conv_func, conv.conv_busy});
        for (int i = 0; i < 3; i++)
        begin
            cmd({1'b1, 4'hd + 4'(i), 3'b000});
            cmp("drivers", 4 >> i, {conv.drv_x_pair, conv.drv_y_pair, conv.drv_yx_pair});
        end
        cmd(8'hdc);
        cmp("reserved", 32'h1, conv.reserved_hold);
        cmd(8'h85);
        cmp("stop", 32'h6, {conv.abort_req, config_reg_zero[CFG0_RES_BIT], conv.reserved_hold});
        pulse(3'b001);
        cmp("abort done", 32'h0, conv.abort_req);
        cmp("starts", 32'h9, starts);
        cmd(8'h82);
        cmp("soft reset", 32'h0, {conv.resolution_select, config_reg_zero});
        $display("test conv done");
    endtask
    task automatic t_access();
        cmd(8'h2b);
        cmp("pointer", 32'h5, regacc.read_ptr);
        cmp("bias", 32'h2, {conv.bias_keep_on, conv.conv_busy});
        xfer(AW, 24'h602001, 3);
        cmp("reg write", {4'hc, 16'h2001}, {regacc.wr_addr, regacc.wr_data});
        cmp("cfg copy", 32'h2001, config_reg_zero);
        cmp("strobes", 32'h1, strobes);
        apb(1'b0, OFS_LASTWR, 32'h0);
        cmp("last write", 32'h000c2001, rd);
        $display("test access done");
    endtask
    task automatic t_disable();
        apb(1'b1, OFS_CTRL, 32'h0);
        xfer(AW, 24'h0, 0);
        cmp("ack disabled", 32'h0, ack);
        apb(1'b1, OFS_CTRL, 32'h1);
        xfer(AW, 24'h0, 0);
        cmp("ack enabled", 32'h1, ack);
        $display("test disable done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        {psel, penable, pwrite, conv_done, pen_lifted, abort_done, paddr, pwdata} = '0;
        {strap_hi, strap_lo} = 2'b10;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        t_regs();
        t_addr();
        t_conv();
        t_access();
        t_disable();
        conclude();
    end
    initial
    begin
        #3000000;
        errors++;
        conclude();
    end
endmodule
